// ---- src/rscf_pkg.sv ----
// Constants for the reset source combiner and its cause flags
package rscf_pkg;

    // ==========================================================
    // Register map
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned DATA_W  = 16;
    localparam logic [3:0]  RCS_OFF = 4'h0;

    // ==========================================================
    // Field positions of reset_cause_status
    localparam int unsigned POS_TRAP  = 15;
    localparam int unsigned POS_ILL   = 14;
    localparam int unsigned POS_VREG  = 8;
    localparam int unsigned POS_EXT   = 7;
    localparam int unsigned POS_SOFT  = 6;
    localparam int unsigned POS_SWDT  = 5;
    localparam int unsigned POS_TMO   = 4;
    localparam int unsigned POS_SLEEP = 3;
    localparam int unsigned POS_IDLE  = 2;
    localparam int unsigned POS_BOR   = 1;
    localparam int unsigned POS_POR   = 0;

    // ==========================================================
    // Implemented bits and values
    localparam logic [15:0] RCS_MASK   = 16'hc1ff;
    localparam logic [15:0] RCS_RST    = 16'h0003;
    localparam logic [15:0] RCS_BORCLR = 16'hc07c;
    localparam logic [15:0] RCS_PSVCLR = 16'h0010;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_NS   = 40;
    localparam int unsigned TRST_NS  = 20000;
    localparam int unsigned TRST_CYC = (TRST_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W    = 10;

endpackage

// ---- src/rscf_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module rscf_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic pin_in,
    output logic      level_q
);

    // ==========================================================
    // State
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } rscf_sync_t;

    rscf_sync_t st_q;
    rscf_sync_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Accept only when stages two and three agree
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= {4{RST_VAL}};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_q = st_q.lvl;

endmodule // rscf_sync

// ---- src/rscf_top.sv ----
// Reset source combiner with reset cause status register
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module rscf_top #(
    parameter int unsigned HOLD_CYC = rscf_pkg::TRST_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    input  wire logic                     brown_out_reset_n,
    input  wire logic                     external_clear_pin_n,
    input  wire logic                     soft_reset_req,
    input  wire logic                     watchdog_timeout,
    input  wire logic                     trap_conflict,
    input  wire logic                     illegal_access,
    input  wire logic                     sleep_entry,
    input  wire logic                     idle_entry,
    input  wire logic                     power_save_instruction,
    input  wire logic                     fuse_watchdog_enable,
    input  wire logic [rscf_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [rscf_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [rscf_pkg::DATA_W-1:0]   reg_rdata,
    output logic                          master_reset_signal_n,
    output logic                          watchdog_enable,
    output logic                          regulator_sleep_standby
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [15:0]                 status;
        logic [15:0]                 rdata;
        logic [rscf_pkg::CNT_W-1:0]  cnt;
        logic                        mrst_n;
        logic                        wdt_en;
        logic                        vreg;
    } rscf_state_t;

    rscf_state_t st_q;
    rscf_state_t st_d;

    logic        bor_lvl;
    logic        ext_lvl;
    logic        bor_act;
    logic        ext_act;
    logic        src_any;
    logic        wr_hit;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [15:0] base_v;

    // ==========================================================
    // Pin synchronisers
    rscf_sync #(.RST_VAL(1'b1)) u_bor_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin_in  (brown_out_reset_n),
        .level_q (bor_lvl)
    );

    rscf_sync #(.RST_VAL(1'b1)) u_ext_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin_in  (external_clear_pin_n),
        .level_q (ext_lvl)
    );

    assign bor_act = !bor_lvl;
    assign ext_act = !ext_lvl;

    assign src_any = bor_act | ext_act | soft_reset_req
                   | watchdog_timeout | trap_conflict
                   | illegal_access;

    assign wr_hit = reg_wr && (reg_addr == rscf_pkg::RCS_OFF);

    // ==========================================================
    // Next state
    always_comb begin
        st_d  = st_q;
        set_v = 16'h0000;
        clr_v = 16'h0000;
        set_v[rscf_pkg::POS_TRAP]  = trap_conflict;
        set_v[rscf_pkg::POS_ILL]   = illegal_access;
        set_v[rscf_pkg::POS_EXT]   = ext_act;
        set_v[rscf_pkg::POS_SOFT]  = soft_reset_req;
        set_v[rscf_pkg::POS_TMO]   = watchdog_timeout;
        set_v[rscf_pkg::POS_SLEEP] = sleep_entry;
        set_v[rscf_pkg::POS_IDLE]  = idle_entry;
        set_v[rscf_pkg::POS_BOR]   = bor_act;
        if (bor_act) begin
            clr_v = clr_v | rscf_pkg::RCS_BORCLR;
        end
        if (power_save_instruction) begin
            clr_v = clr_v | rscf_pkg::RCS_PSVCLR;
        end
        base_v = wr_hit ? (reg_wdata & rscf_pkg::RCS_MASK) : st_q.status;
        st_d.status = (base_v & ~clr_v) | set_v;

        // Read data valid one cycle after strobe only
        st_d.rdata = 16'h0000;
        if (reg_rd && (reg_addr == rscf_pkg::RCS_OFF)) begin
            st_d.rdata = st_q.status & rscf_pkg::RCS_MASK;
        end

        // Reset stretch while any source active
        // Status writes do not load counter
        if (src_any) begin
            st_d.cnt = HOLD_CYC[rscf_pkg::CNT_W-1:0];
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        st_d.mrst_n = !src_any && (st_q.cnt == '0);

        st_d.wdt_en = st_q.status[rscf_pkg::POS_SWDT]
                    | fuse_watchdog_enable;
        st_d.vreg = st_q.status[rscf_pkg::POS_VREG];
    end

    // ==========================================================
    // Registers
    // Only power-on resets this state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q.status <= rscf_pkg::RCS_RST;
            st_q.rdata  <= 16'h0000;
            st_q.cnt    <= HOLD_CYC[rscf_pkg::CNT_W-1:0];
            st_q.mrst_n <= 1'b0;
            st_q.wdt_en <= 1'b0;
            st_q.vreg   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata               = st_q.rdata;
    assign master_reset_signal_n   = st_q.mrst_n;
    assign watchdog_enable         = st_q.wdt_en;
    assign regulator_sleep_standby = st_q.vreg;

    // ==========================================================
    // Checks
    logic started_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    por_value_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !started_q |-> st_q.status == rscf_pkg::RCS_RST)
        else $error("status wrong after power-on");

    mrst_any_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        src_any |=> !master_reset_signal_n [*2])
        else $error("master reset not asserted");

    bor_reset_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(bor_lvl) |=> !master_reset_signal_n && st_q.status[1])
        else $error("brown-out not combined");

    trap_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        trap_conflict |=> st_q.status[rscf_pkg::POS_TRAP])
        else $error("trap flag not set");

    illegal_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        illegal_access |=> st_q.status[rscf_pkg::POS_ILL])
        else $error("illegal flag not set");

    unimpl_zero_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        reg_rdata[13:9] == 5'h00)
        else $error("unimplemented bits not zero");

    soft_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        soft_reset_req |=> st_q.status[rscf_pkg::POS_SOFT])
        else $error("soft reset flag not set");

    tmo_clear_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        power_save_instruction && !watchdog_timeout
        |=> !st_q.status[rscf_pkg::POS_TMO])
        else $error("timeout flag not cleared");

    set_wins_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        watchdog_timeout && wr_hit |=> st_q.status[4])
        else $error("write beat hardware set");

    wdt_fuse_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        fuse_watchdog_enable |=> watchdog_enable)
        else $error("watchdog not forced on");

    vreg_follow_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        ##1 regulator_sleep_standby == $past(st_q.status[8]))
        else $error("regulator control mismatch");

    write_norst_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        wr_hit && !src_any && st_q.cnt == '0
        |=> master_reset_signal_n)
        else $error("write caused reset");

    ext_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        ext_act |=> st_q.status[rscf_pkg::POS_EXT])
        else $error("external pin flag not set");

    tmo_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        watchdog_timeout |=> st_q.status[rscf_pkg::POS_TMO])
        else $error("timeout flag not set");

    sleep_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        sleep_entry |=> st_q.status[rscf_pkg::POS_SLEEP])
        else $error("sleep flag not set");

    idle_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        idle_entry |=> st_q.status[rscf_pkg::POS_IDLE])
        else $error("idle flag not set");

    bor_flag_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        bor_act |=> st_q.status[rscf_pkg::POS_BOR])
        else $error("brown-out flag not set");

    bor_clear_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        bor_act && !watchdog_timeout
        |=> !st_q.status[rscf_pkg::POS_TMO])
        else $error("timeout flag kept on brown-out");

    wdt_soft_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        st_q.status[rscf_pkg::POS_SWDT] |=> watchdog_enable)
        else $error("watchdog not enabled by bit");

endmodule // rscf_top

// ---- verification/rscf_src_model.sv ----
// Model of the reset sources and CPU fault logic
`timescale 1ns/1ps

module rscf_src_model (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [3:0] sel,
    input  wire logic       go,
    output logic [8:0]      pulse_q,
    output logic            brown_out_reset_n,
    output logic            external_clear_pin_n
);
    logic [2:0] cnt_q;
    logic       bor_q;

    // ==========================================================
    // Event pulses and pin holds
    // nine selectable events, six of them reset sources
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pulse_q <= 9'h000;
            cnt_q   <= 3'h0;
            bor_q   <= 1'b0;
        end else begin
            pulse_q <= go ? (9'h001 << sel) : 9'h000;
            if (go && (sel == 4'h4 || sel == 4'h5)) begin
                cnt_q <= 3'h6;
                bor_q <= (sel == 4'h5);
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    assign brown_out_reset_n    = !(cnt_q != 3'h0 && bor_q);
    assign external_clear_pin_n = !(cnt_q != 3'h0 && !bor_q);
endmodule // rscf_src_model

// ---- verification/rscf_top_bench.sv ----
// Self-checking bench for the reset source combiner
`timescale 1ns/1ps

module rscf_top_bench;
    typedef struct packed {
        logic [3:0]  src;
        logic [15:0] pre;
        logic [15:0] exp;
        logic        rst;
    } rscf_row_t;

    localparam int HOLD = 4;
    logic        clk_sys, arst_n, reg_wr, reg_rd, fuse, go;
    logic [3:0]  reg_addr, sel;
    logic [15:0] reg_wdata, reg_rdata;
    logic [8:0]  pulse;
    logic        bor_n, ext_n, mrst_n, wd_en, vreg;
    int          miscompares, comparisons;
    rscf_row_t   rows [9];

    rscf_src_model i_rscf_src_model (.clk_sys(clk_sys), .arst_n(arst_n),
        .sel(sel), .go(go), .pulse_q(pulse), .brown_out_reset_n(bor_n),
        .external_clear_pin_n(ext_n));

    rscf_top #(.HOLD_CYC(HOLD)) i_rscf_top (.clk_sys(clk_sys),
        .arst_n(arst_n), .brown_out_reset_n(bor_n),
        .external_clear_pin_n(ext_n), .soft_reset_req(pulse[2]),
        .watchdog_timeout(pulse[3]), .trap_conflict(pulse[0]),
        .illegal_access(pulse[1]), .sleep_entry(pulse[6]),
        .idle_entry(pulse[7]), .power_save_instruction(pulse[8]),
        .fuse_watchdog_enable(fuse), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .master_reset_signal_n(mrst_n),
        .watchdog_enable(wd_en), .regulator_sleep_standby(vreg));

    // ==========================================================
    // Clock and checking tasks
    always #20 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(string n, logic e, logic g);
        chk16(n, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk16("reg_rdata", e, reg_rdata);
    endtask

    task automatic fire(logic [3:0] s);
        @(posedge clk_sys);
        sel <= s;
        go  <= 1'b1;
        @(posedge clk_sys);
        go  <= 1'b0;
    endtask

    task automatic wait_rst(logic cnt_chk);
        int k, n;
        n = 0;
        for (k = 0; k < 20 && mrst_n !== 1'b0; k++) begin
            @(posedge clk_sys);
            #1;
        end
        if (k == 20) begin
            miscompares++;
            $display("[ERR] master_reset wait expected 0 seen 1");
            conclude();
        end
        for (k = 0; k < 40 && mrst_n !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (k == 40) begin
            miscompares++;
            $display("[ERR] master_reset wait expected 1 seen 0");
            conclude();
        end
        if (cnt_chk) chk16("hold_cycles", 16'(HOLD + 1), 16'(n));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        clk_sys = 0; arst_n = 0; reg_wr = 0; reg_rd = 0; go = 0;
        fuse = 0; sel = 4'h0; reg_addr = 4'h0; reg_wdata = 16'h0000;
        rows = '{'{4'h0, 16'h0000, 16'h8000, 1'b1},
                 '{4'h1, 16'h0000, 16'h4000, 1'b1},
                 '{4'h2, 16'h0000, 16'h0040, 1'b1},
                 '{4'h3, 16'h0000, 16'h0010, 1'b1},
                 '{4'h4, 16'h0000, 16'h0080, 1'b1},
                 '{4'h5, 16'hc1fc, 16'h0182, 1'b1},
                 '{4'h6, 16'h0000, 16'h0008, 1'b0},
                 '{4'h7, 16'h0000, 16'h0004, 1'b0},
                 '{4'h8, 16'h0010, 16'h0000, 1'b0}};
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        wait_rst(1'b0);
        rd(4'h0, 16'h0003);
        $display("power-on test done");
        foreach (rows[i]) begin
            wr(4'h0, rows[i].pre);
            fire(rows[i].src);
            if (rows[i].rst) begin
                wait_rst(rows[i].src < 4'h4);
            end else begin
                repeat (6) @(posedge clk_sys);
                #1;
                chk1("master_reset", 1'b1, mrst_n);
            end
            rd(4'h0, rows[i].exp);
            $display("source row %0d done", i);
        end
        wr(4'h0, 16'h0120);
        repeat (2) @(posedge clk_sys);
        #1;
        chk1("watchdog_enable", 1'b1, wd_en);
        chk1("regulator", 1'b1, vreg);
        wr(4'h0, 16'h0000);
        fuse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk1("watchdog_enable", 1'b1, wd_en);
        chk1("regulator", 1'b0, vreg);
        @(posedge clk_sys);
        fuse <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk1("watchdog_enable", 1'b0, wd_en);
        $display("control test done");
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'hc1ff);
        chk1("master_reset", 1'b1, mrst_n);
        wr(4'h3, 16'h0000);
        rd(4'h3, 16'h0000);
        rd(4'h0, 16'hc1ff);
        $display("software write test done");
        @(posedge clk_sys);
        sel <= 4'h0;
        go  <= 1'b1;
        @(posedge clk_sys);
        go        <= 1'b0;
        reg_addr  <= 4'h0;
        reg_wdata <= 16'h0000;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
        wait_rst(1'b1);
        rd(4'h0, 16'h8000);
        $display("collision test done");
        arst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk1("master_reset", 1'b0, mrst_n);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        wait_rst(1'b0);
        rd(4'h0, 16'h0003);
        $display("second power-on test done");
        conclude();
    end
endmodule // rscf_top_bench
